// ---- design/ssr_pkg.sv ----
package ssr_pkg;

  // ----------------------------------------------------------------
  // frame and field sizes
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int SOA_W = 5;
  localparam int NIB_W = 4;
  localparam int NCH = 4;
  localparam int OCLO_W = 3;
  localparam int BLANK_W = 2;
  localparam int WDP_W = 2;
  localparam int CNT_W = 5;
  localparam int WD_W = 32;
  localparam logic [CNT_W-1:0] BIT_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] BIT_OVER = 5'h10;
  localparam logic [3:0] IDX_MAX = 4'hf;

  // ----------------------------------------------------------------
  // data bit positions inside a command
  // ----------------------------------------------------------------
  localparam int DB_OCHI = 3;
  localparam int DB_OLDIS = 3;
  localparam int DB_OCDIS = 2;
  localparam int DB_SLEW = 3;
  localparam int DB_CSHI = 2;
  localparam int DB_CSEN = 1;
  localparam int DB_OTU_A = 3;
  localparam int DB_OTU_B = 2;
  localparam int DB_UVDIS = 1;
  localparam int DB_OVDIS = 0;
  localparam int CH_ZERO = 0;
  localparam int CH_ONE = 1;
  localparam int CH_TWO = 2;
  localparam int CH_THREE = 3;

  // ----------------------------------------------------------------
  // status-select addresses
  // ----------------------------------------------------------------
  localparam logic [SOA_W-1:0] SOA_SPI_ON = 5'h01;
  localparam logic [SOA_W-1:0] SOA_UOVR = 5'h05;
  localparam logic [SOA_W-1:0] SOA_PIN0 = 5'h06;
  localparam logic [SOA_W-1:0] SOA_CSNS = 5'h09;
  localparam logic [SOA_W-1:0] SOA_WDR = 5'h0d;
  localparam logic [SOA_W-1:0] SOA_PIN1 = 5'h0e;
  localparam logic [SOA_W-1:0] SOA_PIN2 = 5'h0f;
  localparam logic [2:0] SOA_LO_FAULT = 3'h0;
  localparam logic [2:0] SOA_LO_OCL = 3'h2;
  localparam logic [2:0] SOA_LO_TIM = 3'h3;
  localparam logic [2:0] SOA_LO_DRV = 3'h4;

  // ----------------------------------------------------------------
  // watchdog periods (ms) and clock rate
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint WD_T0_MS = 10;
  localparam longint WD_T1_MS = 50;
  localparam longint WD_T2_MS = 100;
  localparam longint WD_T3_MS = 200;
  localparam longint MS_PER_S = 1000;
  localparam int unsigned WD_CYC0_DEF = int'(WD_T0_MS * CLK_HZ / MS_PER_S);
  localparam int unsigned WD_CYC1_DEF = int'(WD_T1_MS * CLK_HZ / MS_PER_S);
  localparam int unsigned WD_CYC2_DEF = int'(WD_T2_MS * CLK_HZ / MS_PER_S);
  localparam int unsigned WD_CYC3_DEF = int'(WD_T3_MS * CLK_HZ / MS_PER_S);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_STAT = 3'h0,
    CMD_OUT = 3'h1,
    CMD_OCL = 3'h2,
    CMD_TIM = 3'h3,
    CMD_DRV = 3'h4,
    CMD_UOV = 3'h5,
    CMD_WDR = 3'h6,
    CMD_NOP = 3'h7
  } ssr_cmd_t;

  typedef struct packed {
    logic wd_toggle;
    ssr_cmd_t cmd;
    logic [1:0] chan;
    logic [4:0] rsvd;
    logic [4:0] data;
  } ssr_cmd_word_t;

  typedef struct packed {
    logic wd_toggle;
    logic uv;
    logic ov;
    logic [SOA_W-1:0] soa;
    logic [NCH-1:0] ch_fault;
    logic [NIB_W-1:0] nibble;
  } ssr_status_t;

  typedef struct packed {
    logic ot;
    logic oc_hi;
    logic oc_lo;
    logic open_load;
  } ssr_fault_t;

  typedef struct packed {
    logic [OCLO_W-1:0] oc_lo;
    logic oc_hi;
    logic [BLANK_W-1:0] blank;
    logic oc_dis;
    logic ol_dis;
    logic fast_slew;
    logic csns_high;
    logic csns_en;
    logic ot_unlatch;
  } ssr_ch_cfg_t;

  localparam ssr_ch_cfg_t CH_CFG_RST = '0;
  localparam logic [WDP_W-1:0] WDP_RST = 2'h0;
  localparam logic [SOA_W-1:0] SOA_RST = 5'h00;
  localparam int SYNC_W = 29;

endpackage : ssr_pkg

// ---- design/ssr_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssr_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ssr_sync2
`default_nettype wire

// ---- design/ssr_switch_core.sv ----
// Overview of operation
// - expired flag one means fail-safe mode
// - expired flag zero means normal mode
// - pin status shows fail-safe output states
// - pin status bit1 shows watchdog enable
// - pin status bit0 shows wake level
// - input status mirrors four direct inputs
// - status shows overtemperature latch for 3,2
// - without host all settings stay default
// - grounded strap disables watchdog and fail-safe
// - direct input or host command switches outputs
// - fault pin low on any fault
// - overcurrent levels configurable and disableable
// - four selectable watchdog periods, default zero
// - current sense two ratios, default off
// - two slew modes, default slow
// - overtemperature unlatchable, voltage protection disableable
// - reset loads all default settings
// - status echoes previous select address
// - status msb echoes previous toggle bit
`timescale 1ns/1ps
`default_nettype none
module ssr_switch_core #(
  parameter int unsigned WD_CYC0 = ssr_pkg::WD_CYC0_DEF,
  parameter int unsigned WD_CYC1 = ssr_pkg::WD_CYC1_DEF,
  parameter int unsigned WD_CYC2 = ssr_pkg::WD_CYC2_DEF,
  parameter int unsigned WD_CYC3 = ssr_pkg::WD_CYC3_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic so_data,
  output logic so_oe,
  // pins
  input wire logic [ssr_pkg::NCH-1:0] direct_inputs,
  input wire logic wake_pin,
  input wire logic failsafe_strap_input,
  input wire logic [1:0] failsafe_state,
  // analog fault events
  input wire ssr_pkg::ssr_fault_t [ssr_pkg::NCH-1:0] ch_fault_in,
  input wire logic uv_event,
  input wire logic ov_event,
  // switch control and configuration
  output logic [ssr_pkg::NCH-1:0] out_on,
  output logic fault_status_pin_n,
  output ssr_pkg::ssr_ch_cfg_t [ssr_pkg::NCH-1:0] ch_cfg,
  output logic uv_prot_en,
  output logic ov_prot_en,
  output logic [ssr_pkg::WDP_W-1:0] wd_period,
  output logic watchdog_expired_flag
);
  import ssr_pkg::*;

  // ----------------------------------------------------------------
  // link domain: receive and transmit
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] bit_cnt;
  logic [WORD_W-1:0] rx_shift;
  logic [WORD_W-1:0] rx_word;
  logic rx_tgl;
  logic rx_long;
  ssr_status_t status_q;

  always_ff @(negedge sclk or posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= '0;
    end else if (cs_n) begin
      bit_cnt <= '0;
    end else if (bit_cnt != BIT_OVER) begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift <= '0;
    end else begin
      rx_shift <= {rx_shift[WORD_W-2:0], mosi};
    end
  end

  // word captured on 16th bit; a 17th bit marks the frame invalid
  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_word <= '0;
      rx_tgl <= 1'b0;
      rx_long <= 1'b0;
    end else if (bit_cnt == BIT_LAST) begin
      rx_word <= {rx_shift[WORD_W-2:0], mosi};
      rx_tgl <= ~rx_tgl;
      rx_long <= 1'b0;
    end else if (bit_cnt == BIT_OVER) begin
      rx_long <= 1'b1;
    end
  end

  // status_q is frozen while a frame is open
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      so_data <= 1'b0;
    end else if (bit_cnt[CNT_W-1]) begin
      so_data <= 1'b0;
    end else begin
      so_data <= status_q[IDX_MAX - bit_cnt[3:0]];
    end
  end

  always_ff @(posedge sclk or posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      so_oe <= 1'b0;
    end else if (cs_n) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // crossing into the core domain
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic cs_idle;
  logic tgl_s;
  logic long_s;
  logic wake_s;
  logic strap_s;
  logic [NCH-1:0] din_s;
  logic [1:0] fs_state_s;
  ssr_fault_t [NCH-1:0] flt_s;
  logic uv_s;
  logic ov_s;

  assign sync_in = {cs_n, rx_tgl, rx_long, wake_pin, failsafe_strap_input, direct_inputs,
                    failsafe_state, ch_fault_in, uv_event, ov_event};
  assign {cs_idle, tgl_s, long_s, wake_s, strap_s, din_s, fs_state_s, flt_s, uv_s, ov_s} = sync_out;

  ssr_sync2 #(.W(SYNC_W)) u_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .d(sync_in),
    .q(sync_out)
  );

  // ----------------------------------------------------------------
  // frame acceptance
  // ----------------------------------------------------------------
  logic cs_idle_d;
  logic tgl_seen;
  logic accept;
  ssr_cmd_word_t cmd_w;

  assign cmd_w = ssr_cmd_word_t'(rx_word);
  assign accept = cs_idle & ~cs_idle_d & (tgl_s != tgl_seen) & ~long_s;

  // an overlong frame is dropped as if it never happened
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_idle_d <= 1'b1;
      tgl_seen <= 1'b0;
    end else begin
      cs_idle_d <= cs_idle;
      if (cs_idle & ~cs_idle_d) begin
        tgl_seen <= tgl_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [SOA_W-1:0] soa;
  logic [NCH-1:0] spi_on;
  logic last_wd_tgl;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      soa <= SOA_RST;
      spi_on <= '0;
      uv_prot_en <= 1'b1;
      ov_prot_en <= 1'b1;
      wd_period <= WDP_RST;
      ch_cfg <= {NCH{CH_CFG_RST}};
    end else if (accept) begin
      unique case (cmd_w.cmd)
        CMD_STAT: soa <= cmd_w.data;
        CMD_OUT: spi_on <= cmd_w.data[NIB_W-1:0];
        CMD_OCL: begin
          ch_cfg[cmd_w.chan].oc_hi <= cmd_w.data[DB_OCHI];
          ch_cfg[cmd_w.chan].oc_lo <= cmd_w.data[OCLO_W-1:0];
        end
        CMD_TIM: begin
          ch_cfg[cmd_w.chan].ol_dis <= cmd_w.data[DB_OLDIS];
          ch_cfg[cmd_w.chan].oc_dis <= cmd_w.data[DB_OCDIS];
          ch_cfg[cmd_w.chan].blank <= cmd_w.data[BLANK_W-1:0];
        end
        CMD_DRV: begin
          ch_cfg[cmd_w.chan].fast_slew <= cmd_w.data[DB_SLEW];
          ch_cfg[cmd_w.chan].csns_high <= cmd_w.data[DB_CSHI];
          ch_cfg[cmd_w.chan].csns_en <= cmd_w.data[DB_CSEN];
        end
        CMD_UOV: begin
          ch_cfg[CH_ONE].ot_unlatch <= cmd_w.data[DB_OTU_A];
          ch_cfg[CH_ZERO].ot_unlatch <= cmd_w.data[DB_OTU_B];
          uv_prot_en <= ~cmd_w.data[DB_UVDIS];
          ov_prot_en <= ~cmd_w.data[DB_OVDIS];
        end
        CMD_WDR: begin
          ch_cfg[CH_THREE].ot_unlatch <= cmd_w.data[DB_OTU_A];
          ch_cfg[CH_TWO].ot_unlatch <= cmd_w.data[DB_OTU_B];
          wd_period <= cmd_w.data[WDP_W-1:0];
        end
        CMD_NOP: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic [WD_W-1:0] wd_cnt;
  logic [WD_W-1:0] wd_limit;
  logic wd_refresh;

  assign wd_refresh = accept & (cmd_w.wd_toggle != last_wd_tgl);

  always_comb begin
    unique case (wd_period)
      2'h0: wd_limit = WD_W'(WD_CYC0);
      2'h1: wd_limit = WD_W'(WD_CYC1);
      2'h2: wd_limit = WD_W'(WD_CYC2);
      2'h3: wd_limit = WD_W'(WD_CYC3);
    endcase
  end

  // grounded strap keeps the watchdog and fail-safe off
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_cnt <= '0;
      last_wd_tgl <= 1'b0;
      watchdog_expired_flag <= 1'b0;
    end else begin
      if (accept) begin
        last_wd_tgl <= cmd_w.wd_toggle;
      end
      if (!strap_s) begin
        wd_cnt <= '0;
        watchdog_expired_flag <= 1'b0;
      end else if (!watchdog_expired_flag) begin
        if (wd_refresh) begin
          wd_cnt <= '0;
        end else if (wd_cnt >= wd_limit - 1'b1) begin
          watchdog_expired_flag <= 1'b1;
        end else begin
          wd_cnt <= wd_cnt + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output control and fault latching
  // ----------------------------------------------------------------
  logic [NCH-1:0] fs_req;
  logic [NCH-1:0] req_on;
  logic [NCH-1:0] req_on_d;
  ssr_fault_t [NCH-1:0] flt_q;
  logic [NCH-1:0] ch_bad;
  logic uv_flag;
  logic ov_live;

  assign fs_req = {1'b0, fs_state_s[1], 1'b0, fs_state_s[0]};
  assign ov_live = ov_s & ov_prot_en;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      ssr_fault_t set_f;
      logic off_edge;

      // fail-safe drives outputs two and zero only
      assign req_on[gi] = watchdog_expired_flag ? fs_req[gi]
                        : (din_s[gi] | spi_on[gi]);
      assign off_edge = req_on_d[gi] & ~req_on[gi];
      assign set_f.ot = flt_s[gi].ot;
      assign set_f.oc_hi = flt_s[gi].oc_hi & ~ch_cfg[gi].oc_dis;
      assign set_f.oc_lo = flt_s[gi].oc_lo & ~ch_cfg[gi].oc_dis;
      assign set_f.open_load = flt_s[gi].open_load & ~ch_cfg[gi].ol_dis;
      assign ch_bad[gi] = flt_q[gi].ot | flt_q[gi].oc_hi | flt_q[gi].oc_lo;

      // set wins over the clear made by a switch-off
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          flt_q[gi] <= '0;
        end else begin
          flt_q[gi].oc_hi <= set_f.oc_hi | (flt_q[gi].oc_hi & ~off_edge);
          flt_q[gi].oc_lo <= set_f.oc_lo | (flt_q[gi].oc_lo & ~off_edge);
          flt_q[gi].open_load <= set_f.open_load;
          if (ch_cfg[gi].ot_unlatch) begin
            flt_q[gi].ot <= set_f.ot;
          end else begin
            flt_q[gi].ot <= set_f.ot | (flt_q[gi].ot & ~off_edge);
          end
        end
      end

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          out_on[gi] <= 1'b0;
        end else begin
          out_on[gi] <= req_on[gi] & ~ch_bad[gi] & ~uv_flag & ~ov_live;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_on_d <= '0;
      uv_flag <= 1'b0;
      fault_status_pin_n <= 1'b1;
    end else begin
      req_on_d <= req_on;
      uv_flag <= (uv_s & uv_prot_en) | (uv_flag & ~(|(req_on_d & ~req_on)));
      fault_status_pin_n <= ~((|flt_q) | uv_flag | ov_live);
    end
  end

  // ----------------------------------------------------------------
  // status word, refreshed only between frames
  // ----------------------------------------------------------------
  ssr_status_t next_status;
  ssr_ch_cfg_t sel_cfg;

  assign sel_cfg = ch_cfg[soa[SOA_W-1:SOA_W-2]];

  always_comb begin
    next_status.wd_toggle = last_wd_tgl;
    next_status.uv = uv_flag;
    next_status.ov = ov_live;
    next_status.soa = soa;
    for (int i = 0; i < NCH; i++) begin
      next_status.ch_fault[i] = |flt_q[i];
    end
    next_status.nibble = '0;
    if (soa == SOA_PIN0) begin
      next_status.nibble = {fs_state_s, strap_s, wake_s};
    end else if (soa == SOA_PIN1) begin
      next_status.nibble = din_s;
    end else if (soa == SOA_PIN2) begin
      next_status.nibble = {ch_cfg[CH_THREE].ot_unlatch, ch_cfg[CH_TWO].ot_unlatch,
                            2'h0};
    end else if (soa == SOA_WDR) begin
      next_status.nibble = {1'b0, watchdog_expired_flag, wd_period};
    end else if (soa == SOA_UOVR) begin
      next_status.nibble = {ch_cfg[CH_ONE].ot_unlatch, ch_cfg[CH_ZERO].ot_unlatch,
                            ~uv_prot_en, ~ov_prot_en};
    end else if (soa == SOA_SPI_ON) begin
      next_status.nibble = spi_on;
    end else if (soa == SOA_CSNS) begin
      for (int i = 0; i < NCH; i++) begin
        next_status.nibble[i] = ch_cfg[i].csns_en;
      end
    end else if (soa[2:0] == SOA_LO_FAULT) begin
      next_status.nibble = flt_q[soa[SOA_W-1:SOA_W-2]];
    end else if (soa[2:0] == SOA_LO_OCL) begin
      next_status.nibble = {sel_cfg.oc_hi, sel_cfg.oc_lo};
    end else if (soa[2:0] == SOA_LO_TIM) begin
      next_status.nibble = {sel_cfg.ol_dis, sel_cfg.oc_dis, sel_cfg.blank};
    end else if (soa[2:0] == SOA_LO_DRV) begin
      next_status.nibble = {sel_cfg.fast_slew, sel_cfg.csns_high, sel_cfg.csns_en, 1'b0};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= '0;
    end else if (cs_idle & cs_idle_d) begin
      status_q <= next_status;
    end
  end

endmodule : ssr_switch_core
`default_nettype wire

// ---- sim/ssr_switch_core_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssr_switch_core_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic so_data,
  // pins
  input wire logic [ssr_pkg::NCH-1:0] direct_inputs,
  input wire logic failsafe_strap_input,
  input wire logic ov_event,
  // outputs
  input wire logic [ssr_pkg::NCH-1:0] out_on,
  input wire logic fault_status_pin_n,
  input wire ssr_pkg::ssr_ch_cfg_t [ssr_pkg::NCH-1:0] ch_cfg,
  input wire logic uv_prot_en,
  input wire logic ov_prot_en,
  input wire logic [ssr_pkg::WDP_W-1:0] wd_period,
  input wire logic watchdog_expired_flag
);
  import ssr_pkg::*;
  // ----
  // frame tracking
  // ----
  logic [4:0] bcnt;
  logic cur_tog, last_tog;
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bcnt <= 5'h00;
    end else begin
      bcnt <= bcnt + 5'h01;
    end
  end
  always_ff @(negedge sclk) begin
    if (bcnt == 5'h00) begin
      cur_tog <= mosi;
    end
  end
  // only a frame whose bit count is sixteen modulo 32 counts, as bcnt wraps
  always_ff @(posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      last_tog <= 1'b0;
    end else if (bcnt == 5'h10) begin
      last_tog <= cur_tog;
    end
  end
  // ----
  // properties
  // ----
  sequence s_frame_start;
    !cs_n && bcnt == 5'h00;
  endsequence
  sequence s_din_held;
    (direct_inputs[0] && !ov_event && !watchdog_expired_flag) [*5];
  endsequence
  toggle_echo_a: assert property (@(negedge sclk) disable iff (!reset_n)
    s_frame_start |-> so_data == last_tog) else $error("toggle echo wrong");
  reset_vals_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> out_on == '0 && fault_status_pin_n && ch_cfg == '0 && uv_prot_en
      && ov_prot_en && wd_period == '0 && !watchdog_expired_flag) else $error("bad defaults");
  strap_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !failsafe_strap_input [*5] |-> !watchdog_expired_flag) else $error("expired with strap low");
  failsafe_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    watchdog_expired_flag [*2] |-> !out_on[1] && !out_on[3]) else $error("fail-safe outputs on");
  expire_cause_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(watchdog_expired_flag) |-> $past(failsafe_strap_input, 3)) else $error("stray expiry");
  direct_in_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_din_held |-> out_on[0]) else $error("direct input ignored");
  fault_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ov_event [*5] |-> !fault_status_pin_n) else $error("fault pin not low");
  cfg_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cs_n [*8] |-> $stable(ch_cfg) && $stable({wd_period, uv_prot_en, ov_prot_en}))
    else $error("config moved without frame");
endmodule : ssr_switch_core_assertions

bind ssr_switch_core ssr_switch_core_assertions u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
  .so_data(so_data), .direct_inputs(direct_inputs), .ov_event(ov_event),
  .failsafe_strap_input(failsafe_strap_input), .out_on(out_on), .ch_cfg(ch_cfg),
  .fault_status_pin_n(fault_status_pin_n), .uv_prot_en(uv_prot_en),
  .ov_prot_en(ov_prot_en), .wd_period(wd_period),
  .watchdog_expired_flag(watchdog_expired_flag)
);
`default_nettype wire

// ---- sim/ssr_spi_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssr_spi_host (
  // link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic so_data,
  input wire logic so_oe,
  // returned status
  output logic [15:0] rsp_word,
  output logic rsp_stb
);
  initial begin
    {sclk, cs_n, mosi, rsp_stb} = 4'h4;
    rsp_word = '0;
  end
  // ----
  // one frame, msb first
  // ----
  // frames never replayed on a fault
  task automatic xfer(input logic [15:0] w, input int nbits, input int lead);
    logic [15:0] r = '0;
    logic line = 1'b0;
    #1;
    cs_n = 1'b0;
    #(lead);
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      mosi = (i < 16) ? w[15-i] : ~mosi;
      #3;
      sclk = 1'b0;
      // released line reads inverted
      line = so_oe ? so_data : ~line;
      if (i < 16) begin
        r[15-i] = line;
      end
      #3;
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    #60;
    rsp_word = r;
    rsp_stb = ~rsp_stb;
  endtask : xfer
endmodule : ssr_spi_host
`default_nettype wire

// ---- sim/ssr_switch_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssr_switch_core_tb;
  import ssr_pkg::*;
  localparam int unsigned WDC = 300;
  logic ref_clk, reset_n, sclk, cs_n, mosi, so_data, so_oe, wake_pin, failsafe_strap_input;
  logic [NCH-1:0] direct_inputs, out_on;
  logic [1:0] failsafe_state;
  ssr_fault_t [NCH-1:0] ch_fault_in;
  logic uv_event, ov_event, fault_status_pin_n, uv_prot_en, ov_prot_en, rsp_stb;
  ssr_ch_cfg_t [NCH-1:0] ch_cfg;
  logic [WDP_W-1:0] wd_period;
  logic watchdog_expired_flag;
  logic [15:0] rsp_word;
  int error_cnt = 0, checks = 0, lead = 40;
  logic [31:0] exq[$];
  logic m_tog = 1'b0, m_uvd = 1'b0, m_ovd = 1'b0, m_exp = 1'b0;
  logic [4:0] m_soa = 5'h00;
  logic [3:0] m_otu = 4'h0;
  logic [1:0] m_wdp = 2'h0;
  ssr_ch_cfg_t e_cfg [NCH];

  ssr_switch_core #(.WD_CYC0(WDC), .WD_CYC1(400), .WD_CYC2(500), .WD_CYC3(600)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .so_data(so_data), .so_oe(so_oe), .direct_inputs(direct_inputs), .wake_pin(wake_pin),
    .failsafe_strap_input(failsafe_strap_input), .failsafe_state(failsafe_state),
    .ch_fault_in(ch_fault_in), .uv_event(uv_event), .ov_event(ov_event), .out_on(out_on),
    .fault_status_pin_n(fault_status_pin_n), .ch_cfg(ch_cfg), .uv_prot_en(uv_prot_en),
    .ov_prot_en(ov_prot_en), .wd_period(wd_period),
    .watchdog_expired_flag(watchdog_expired_flag));
  ssr_spi_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .so_data(so_data),
    .so_oe(so_oe), .rsp_word(rsp_word), .rsp_stb(rsp_stb));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----
  // helpers
  // ----
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // mask and value of status nibble
  function automatic logic [7:0] nib(input logic [4:0] soa);
    case (soa)
      SOA_PIN0: return {4'hf, failsafe_state, failsafe_strap_input, wake_pin};
      SOA_PIN1: return {4'hf, direct_inputs};
      SOA_PIN2: return {4'hc, m_otu[3:2], 2'h0};
      SOA_WDR: return {4'hf, 1'b0, m_exp, m_wdp};
      SOA_UOVR: return {4'hf, m_otu[1:0], m_uvd, m_ovd};
      default: return 8'hf0;
    endcase
  endfunction : nib
  task automatic send(input ssr_cmd_t c, input logic [1:0] ch, input logic [4:0] d,
                      input int nb = 16);
    logic [7:0] n;
    n = nib(m_soa);
    exq.push_back({12'hfff, n[7:4], m_tog, 2'h0, m_soa, 4'h0, n[3:0]});
    host.xfer({~m_tog, c, ch, 5'h00, d}, nb, lead);
    if (nb == 16) begin
      m_tog = ~m_tog;
      case (c)
        CMD_STAT: m_soa = d;
        CMD_OCL: {e_cfg[ch].oc_hi, e_cfg[ch].oc_lo} = d[3:0];
        CMD_TIM: {e_cfg[ch].ol_dis, e_cfg[ch].oc_dis, e_cfg[ch].blank} = d[3:0];
        CMD_DRV: {e_cfg[ch].fast_slew, e_cfg[ch].csns_high, e_cfg[ch].csns_en} = d[3:1];
        CMD_UOV: {m_otu[1:0], m_uvd, m_ovd} = d[3:0];
        CMD_WDR: {m_otu[3:2], m_wdp} = d[3:0];
        default: ;
      endcase
    end
  endtask : send
  task automatic chk_cfg();
    for (int i = 0; i < NCH; i++) begin
      e_cfg[i].ot_unlatch = m_otu[i];
      chk("ch_cfg", 16'(ch_cfg[i]), 16'(e_cfg[i]));
    end
    chk("prot", {12'h0, uv_prot_en, ov_prot_en, wd_period},
        {12'h0, ~m_uvd, ~m_ovd, m_wdp});
  endtask : chk_cfg

  always @(rsp_stb) begin
    logic [31:0] e;
    if (reset_n === 1'b1) begin
      e = (exq.size() > 0) ? exq.pop_front() : 32'hffff_ffff;
      chk("status", rsp_word & e[31:16],
          e[15:0]);
    end
  end
  initial begin
    cyc(20000);
    chk("timeout", 16'h0001, 16'h0000);
    end_sim();
  end
  // ----
  // tests
  // ----
  initial begin
    void'($urandom(47));
    reset_n = 1'b0;
    direct_inputs = '0;
    wake_pin = 1'b0;
    failsafe_strap_input = 1'b0;
    failsafe_state = 2'h0;
    ch_fault_in = '0;
    uv_event = 1'b0;
    ov_event = 1'b0;
    for (int i = 0; i < NCH; i++) e_cfg[i] = CH_CFG_RST;
    cyc(5);
    reset_n <= 1'b1;
    cyc(4);
    chk("defaults", {6'h0, uv_prot_en, ov_prot_en, fault_status_pin_n,
      watchdog_expired_flag, wd_period, out_on}, 16'h0380);
    cyc(100);
    chk_cfg();
    send(CMD_NOP, 2'h0, 5'h00);
    $display("test defaults done");
    send(CMD_STAT, 2'h0, SOA_PIN1);
    repeat (4) begin
      @(posedge ref_clk) direct_inputs <= 4'($urandom);
      cyc(6);
      chk("out_on", 16'(out_on), 16'(direct_inputs));
      send(CMD_NOP, 2'h0, 5'h00);
    end
    @(posedge ref_clk) direct_inputs <= 4'h0;
    cyc(6);
    send(CMD_OUT, 2'h0, 5'h0a);
    chk("spi on", 16'(out_on), 16'h000a);
    send(CMD_OUT, 2'h0, 5'h1f, 17);
    chk("overlong", 16'(out_on), 16'h000a);
    send(CMD_OUT, 2'h0, 5'h00);
    $display("test switching done");
    send(CMD_STAT, 2'h0, SOA_PIN0);
    repeat (3) begin
      @(posedge ref_clk);
      failsafe_state <= 2'($urandom);
      wake_pin <= 1'($urandom);
      cyc(6);
      send(CMD_NOP, 2'h0, 5'h00);
    end
    $display("test pin status done");
    lead = 100;
    for (int i = 0; i < NCH; i++) begin
      send(CMD_OCL, 2'(i), 5'($urandom) & 5'h0f);
      send(CMD_TIM, 2'(i), 5'($urandom) & 5'h0f);
      send(CMD_DRV, 2'(i), 5'($urandom) & 5'h0e);
    end
    for (int p = 0; p < 4; p++) begin
      send(CMD_WDR, 2'h0, {1'b0, 2'($urandom), 2'(p)});
      chk_cfg();
    end
    send(CMD_UOV, 2'h0, 5'h0f);
    chk_cfg();
    send(CMD_STAT, 2'h0, SOA_PIN2);
    send(CMD_STAT, 2'h0, SOA_UOVR);
    send(CMD_STAT, 2'h0, SOA_WDR);
    send(CMD_UOV, 2'h0, 5'h00);
    send(CMD_WDR, 2'h0, 5'h00);
    chk_cfg();
    lead = 40;
    $display("test config done");
    @(posedge ref_clk);
    failsafe_state <= 2'h3;
    failsafe_strap_input <= 1'b1;
    cyc(6);
    repeat (3) send(CMD_NOP, 2'h0, 5'h00);
    cyc(WDC - 40);
    chk("running", 16'(watchdog_expired_flag), 16'h0000);
    cyc(80);
    m_exp = 1'b1;
    chk("expired", {11'h0, watchdog_expired_flag, out_on}, 16'h0015);
    send(CMD_NOP, 2'h0, 5'h00);
    @(posedge ref_clk) failsafe_strap_input <= 1'b0;
    cyc(6);
    m_exp = 1'b0;
    chk("strap low", 16'(watchdog_expired_flag), 16'h0000);
    send(CMD_NOP, 2'h0, 5'h00);
    $display("test watchdog done");
    @(posedge ref_clk) ov_event <= 1'b1;
    cyc(8);
    chk("fault pin", 16'(fault_status_pin_n), 16'h0000);
    @(posedge ref_clk) ov_event <= 1'b0;
    cyc(8);
    chk("fault gone", 16'(fault_status_pin_n), 16'h0001);
    chk("notes left", 16'(exq.size()), 16'h0000);
    $display("test fault pin done");
    end_sim();
  end
endmodule : ssr_switch_core_tb
`default_nettype wire
